// >>> inc/fail_safe_monitor_pkg.sv
// Constants, types and register layout of the fail-safe clock monitor
package fail_safe_monitor_pkg;

  // Bus geometry
  localparam int ADDR_W = 4;
  localparam int DATA_W = 32;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFS_OSC_CTRL  = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_IRQ_FLAGS = 4'h4;
  localparam logic [ADDR_W-1:0] OFS_IRQ_EN    = 4'h8;
  localparam logic [ADDR_W-1:0] OFS_MODE_CTRL = 4'hc;

  // osc_control_reg fields
  localparam int SCS_LSB    = 0;
  localparam int SCS_MSB    = 1;
  localparam int STATUS_BIT = 3;
  localparam int IFS_LSB    = 4;
  localparam int IFS_MSB    = 6;

  // periph_irq_flags2 and enable fields
  localparam int FAIL_FLAG_BIT = 7;
  localparam int FAIL_EN_BIT   = 7;

  // Mode control write fields
  localparam int SLEEP_BIT = 0;
  localparam int WDCLR_BIT = 1;
  localparam int IDLE_BIT  = 2;

  // Mode control read fields
  localparam int RD_STATE_LSB = 0;
  localparam int RD_STATE_MSB = 3;
  localparam int RD_PM_BIT    = 4;
  localparam int RD_SRC_LSB   = 5;
  localparam int RD_SRC_MSB   = 6;

  // Reset values
  localparam logic [1:0] SCS_RST = 2'h0;
  localparam logic [2:0] IFS_RST = 3'h0;

  // Sample clock divide ratio of the internal RC clock
  localparam int RC_DIV = 64;

  // Bit positions in the synchronised input vector
  localparam int SYN_W     = 8;
  localparam int SYN_MCLK  = 0;
  localparam int SYN_RC    = 1;
  localparam int SYN_READY = 2;
  localparam int SYN_WAKE  = 3;
  localparam int SYN_MON   = 4;
  localparam int SYN_TWO   = 5;
  localparam int SYN_XTAL  = 6;
  localparam int SYN_WDT   = 7;

  typedef enum logic [1:0] {
    SRC_PRIMARY   = 2'h0,
    SRC_SECONDARY = 2'h1,
    SRC_INTERNAL  = 2'h2
  } clk_src_e;

  typedef enum logic [3:0] {
    ST_STARTUP  = 4'b0001,
    ST_RUN      = 4'b0010,
    ST_SLEEP    = 4'b0100,
    ST_FAILSAFE = 4'b1000
  } fsm_e;

  typedef struct packed {
    logic              read;
    logic              write;
    logic [ADDR_W-1:0] address;
    logic [DATA_W-1:0] writedata;
  } avmm_req_s;

  typedef struct packed {
    clk_src_e src;
    logic     primary_en;
    logic     internal_rc_clock_run;
    logic     pm_active;
    logic     sleep_active;
  } clk_ctrl_s;

endpackage : fail_safe_monitor_pkg

// >>> hdl/fail_safe_clock_monitor.sv
// Fail-safe clock monitor with two-speed start-up and register slave
`timescale 1ns/10ps

module fail_safe_clock_monitor #(
  parameter int RC_DIVIDE = fail_safe_monitor_pkg::RC_DIV
) (
  input  wire logic                      ref_clk,
  input  wire logic                      sys_rst,
  input  wire logic                      monitored_clk,
  input  wire logic                      internal_rc_clock,
  input  wire logic                      primary_ready,
  input  wire logic                      wake_event,
  input  wire logic                      monitor_enable_cfg,
  input  wire logic                      two_speed_enable_cfg,
  input  wire logic                      crystal_mode_cfg,
  input  wire logic                      wdt_enable,
  input  wire fail_safe_monitor_pkg::avmm_req_s       avmm_req,
  output logic                           avmm_waitrequest,
  output logic [fail_safe_monitor_pkg::DATA_W-1:0]    avmm_readdata,
  output fail_safe_monitor_pkg::clk_ctrl_s            clk_ctrl,
  output logic                           wdt_clear,
  output logic                           osc_fail_irq
);
  import fail_safe_monitor_pkg::*;

  localparam int HALF    = RC_DIVIDE / 2;
  localparam int CNT_W   = $clog2(HALF);
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(HALF - 1);

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers
  logic [SYN_W-1:0] sync1_r;
  logic [SYN_W-1:0] sync2_r;
  logic             mclk_d_r;
  logic             rc_d_r;

  always_ff @(posedge ref_clk) begin
    sync1_r <= {wdt_enable, crystal_mode_cfg, two_speed_enable_cfg,
                monitor_enable_cfg, wake_event, primary_ready,
                internal_rc_clock, monitored_clk};
    sync2_r <= sync1_r;
    mclk_d_r <= sync2_r[SYN_MCLK];
    rc_d_r   <= sync2_r[SYN_RC];
  end

  logic mclk_fall;
  logic rc_rise;
  assign mclk_fall = mclk_d_r & ~sync2_r[SYN_MCLK];
  assign rc_rise   = sync2_r[SYN_RC] & ~rc_d_r;

  ////////////////////////////////////////////////////////////////////////////
  // Static configuration capture
  logic mon_cfg_r;
  logic two_cfg_r;
  logic xtal_cfg_r;

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      mon_cfg_r  <= sync2_r[SYN_MON];
      two_cfg_r  <= sync2_r[SYN_TWO];
      xtal_cfg_r <= sync2_r[SYN_XTAL];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sample clock divider
  logic [CNT_W-1:0] div_cnt_r;
  logic             sample_r;
  logic             sample_rise;
  logic             sample_fall;

  assign sample_rise = rc_rise && (div_cnt_r == CNT_LAST) && !sample_r;
  assign sample_fall = rc_rise && (div_cnt_r == CNT_LAST) && sample_r;

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      div_cnt_r <= '0;
      sample_r  <= 1'b0;
    end else if (rc_rise) begin
      if (div_cnt_r == CNT_LAST) begin
        div_cnt_r <= '0;
        sample_r  <= ~sample_r;
      end else begin
        div_cnt_r <= div_cnt_r + CNT_W'(1);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus slave handshake
  logic        wait_r;
  logic        acc;
  logic        acc_wr;
  logic [DATA_W-1:0] wd;

  assign acc    = (avmm_req.read | avmm_req.write) && !wait_r;
  assign acc_wr = acc && avmm_req.write;
  assign wd     = avmm_req.writedata;

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      wait_r <= 1'b1;
    end else if ((avmm_req.read | avmm_req.write) && wait_r) begin
      wait_r <= 1'b0;
    end else begin
      wait_r <= 1'b1;
    end
  end

  logic wr_osc;
  logic wr_flags;
  logic wr_en;
  logic wr_mode;
  assign wr_osc   = acc_wr && (avmm_req.address == OFS_OSC_CTRL);
  assign wr_flags = acc_wr && (avmm_req.address == OFS_IRQ_FLAGS);
  assign wr_en    = acc_wr && (avmm_req.address == OFS_IRQ_EN);
  assign wr_mode  = acc_wr && (avmm_req.address == OFS_MODE_CTRL);

  ////////////////////////////////////////////////////////////////////////////
  // Software registers
  logic [1:0] scs_r;
  logic [2:0] ifs_r;
  logic       fail_en_r;
  logic       ifs_change;

  assign ifs_change = wr_osc && (wd[IFS_MSB:IFS_LSB] != ifs_r);

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      scs_r     <= SCS_RST;
      ifs_r     <= IFS_RST;
      fail_en_r <= 1'b0;
    end else begin
      if (wr_osc) begin
        scs_r <= wd[SCS_MSB:SCS_LSB];
        ifs_r <= wd[IFS_MSB:IFS_LSB];
      end
      if (wr_en) begin
        fail_en_r <= wd[FAIL_EN_BIT];
      end
    end
  end

  logic sleep_req;
  logic pm_entry;
  logic [1:0] pm_scs;
  assign sleep_req = wr_mode && wd[SLEEP_BIT];
  assign pm_scs    = wr_osc ? wd[SCS_MSB:SCS_LSB] : scs_r;
  assign pm_entry  = (wr_osc && (wd[SCS_MSB:SCS_LSB] != scs_r))
                   || (wr_mode && wd[IDLE_BIT]);

  function automatic clk_src_e src_of(input logic [1:0] sel);
    if (sel[1]) begin
      src_of = SRC_INTERNAL;
    end else if (sel[0]) begin
      src_of = SRC_SECONDARY;
    end else begin
      src_of = SRC_PRIMARY;
    end
  endfunction : src_of

  ////////////////////////////////////////////////////////////////////////////
  // Clock monitor latch and failure detect
  fsm_e     state_r;
  clk_src_e src_r;
  logic     seen_r;
  logic     mon_active;
  logic     fail_det;

  assign mon_active = mon_cfg_r && (state_r == ST_RUN)
                    && (src_r != SRC_INTERNAL);
  assign fail_det   = mon_active && sample_fall && seen_r;

  always_ff @(posedge ref_clk) begin
    if (sys_rst || !mon_active) begin
      seen_r <= 1'b0;
    end else if (mclk_fall) begin
      seen_r <= 1'b1;
    end else if (sample_rise) begin
      seen_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Oscillator-fail flag
  logic fail_flag_r;

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      fail_flag_r <= 1'b0;
    end else if (fail_det) begin
      fail_flag_r <= 1'b1;
    end else if (wr_flags && !wd[FAIL_FLAG_BIT]) begin
      fail_flag_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Clock source state machine
  logic status_r;
  logic primary_en_r;
  logic pm_active_r;
  logic hold_internal;
  logic sleep_r;

  // Crystal start-up runs internal when two-speed or monitoring is on
  assign hold_internal = xtal_cfg_r && (two_cfg_r || mon_cfg_r);

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      state_r      <= ST_STARTUP;
      src_r        <= SRC_INTERNAL;
      status_r     <= 1'b0;
      primary_en_r <= 1'b1;
      pm_active_r  <= 1'b0;
      sleep_r      <= 1'b0;
    end else begin
      case (state_r)
        ST_STARTUP: begin
          if (sleep_req) begin
            state_r      <= ST_SLEEP;
            primary_en_r <= 1'b0;
            sleep_r      <= 1'b1;
          end else if (pm_entry) begin
            state_r      <= ST_RUN;
            src_r        <= src_of(pm_scs);
            pm_active_r  <= 1'b1;
            status_r     <= (src_of(pm_scs) == SRC_PRIMARY);
            primary_en_r <= (src_of(pm_scs) == SRC_PRIMARY);
          end else if (!xtal_cfg_r || sync2_r[SYN_READY]) begin
            state_r  <= ST_RUN;
            src_r    <= SRC_PRIMARY;
            status_r <= 1'b1;
          end else begin
            // Primary not ready yet: stay, source set from hold_internal
            src_r <= hold_internal ? SRC_INTERNAL : SRC_PRIMARY;
          end
        end
        ST_RUN: begin
          if (fail_det) begin
            state_r <= ST_FAILSAFE;
            src_r   <= SRC_INTERNAL;
            if (pm_active_r && fail_en_r) begin
              pm_active_r <= 1'b0;
            end
          end else if (sleep_req) begin
            state_r      <= ST_SLEEP;
            primary_en_r <= 1'b0;
            sleep_r      <= 1'b1;
          end else if (pm_entry) begin
            src_r        <= src_of(pm_scs);
            pm_active_r  <= 1'b1;
            status_r     <= (src_of(pm_scs) == SRC_PRIMARY);
            primary_en_r <= (src_of(pm_scs) == SRC_PRIMARY);
          end
        end
        ST_FAILSAFE: begin
          // Managed mode kept when the interrupt is off
          if (sleep_req) begin
            state_r      <= ST_SLEEP;
            primary_en_r <= 1'b0;
            sleep_r      <= 1'b1;
          end else if (pm_entry) begin
            state_r      <= ST_RUN;
            src_r        <= src_of(pm_scs);
            pm_active_r  <= 1'b1;
            status_r     <= (src_of(pm_scs) == SRC_PRIMARY);
            primary_en_r <= (src_of(pm_scs) == SRC_PRIMARY);
          end else begin
            src_r <= SRC_INTERNAL;
          end
        end
        ST_SLEEP: begin
          if (sync2_r[SYN_WAKE]) begin
            state_r      <= ST_STARTUP;
            status_r     <= 1'b0;
            sleep_r      <= 1'b0;
            primary_en_r <= 1'b1;
            pm_active_r  <= 1'b0;
            src_r        <= hold_internal ? SRC_INTERNAL : SRC_PRIMARY;
          end
        end
        default: begin
          state_r <= ST_STARTUP;
          sleep_r <= 1'b0;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Watchdog clear, RC run request and interrupt request
  logic wdt_clear_r;
  logic internal_rc_clock_run_r;
  logic irq_r;

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      wdt_clear_r <= 1'b0;
      internal_rc_clock_run_r <= 1'b1;
      irq_r       <= 1'b0;
    end else begin
      wdt_clear_r <= fail_det || sleep_req || ifs_change
                  || (wr_mode && wd[WDCLR_BIT]);
      internal_rc_clock_run_r <= mon_cfg_r || sync2_r[SYN_WDT]
                  || (src_r == SRC_INTERNAL)
                  || (state_r == ST_STARTUP);
      irq_r       <= fail_flag_r && fail_en_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data
  logic [DATA_W-1:0] rdata_r;

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      rdata_r <= '0;
    end else if ((avmm_req.read | avmm_req.write) && wait_r) begin
      rdata_r <= '0;
      if (avmm_req.address == OFS_OSC_CTRL) begin
        rdata_r[SCS_MSB:SCS_LSB] <= scs_r;
        rdata_r[STATUS_BIT]      <= status_r;
        rdata_r[IFS_MSB:IFS_LSB] <= ifs_r;
      end else if (avmm_req.address == OFS_IRQ_FLAGS) begin
        rdata_r[FAIL_FLAG_BIT] <= fail_flag_r;
      end else if (avmm_req.address == OFS_IRQ_EN) begin
        rdata_r[FAIL_EN_BIT] <= fail_en_r;
      end else if (avmm_req.address == OFS_MODE_CTRL) begin
        rdata_r[RD_STATE_MSB:RD_STATE_LSB] <= state_r;
        rdata_r[RD_PM_BIT]                 <= pm_active_r;
        rdata_r[RD_SRC_MSB:RD_SRC_LSB]     <= src_r;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign avmm_waitrequest     = wait_r;
  assign avmm_readdata        = rdata_r;
  assign wdt_clear            = wdt_clear_r;
  assign osc_fail_irq         = irq_r;
  assign clk_ctrl.src         = src_r;
  assign clk_ctrl.primary_en  = primary_en_r;
  assign clk_ctrl.internal_rc_clock_run   = internal_rc_clock_run_r;
  assign clk_ctrl.pm_active   = pm_active_r;
  assign clk_ctrl.sleep_active = sleep_r;

endmodule : fail_safe_clock_monitor

// >>> bench/ext_osc_model.sv
// External crystal or clock source model at the monitored clock input
`timescale 1ns/10ps

module ext_osc_model #(
  parameter real HALF_NS = 12.0
) (
  input  wire logic run,
  input  wire logic stable,
  output logic      osc_out,
  output logic      osc_ready
);
  // Clock stands low while stopped; ready follows the stable input
  initial begin
    osc_out = 1'b0;
    forever begin
      #(HALF_NS);
      osc_out = run ? ~osc_out : 1'b0;
    end
  end
  assign osc_ready = stable;
endmodule : ext_osc_model

// >>> bench/fail_safe_monitor_checker.sv
// Port-level assertions for the fail-safe clock monitor
`timescale 1ns/10ps

module fail_safe_monitor_checker #(
  parameter int RC_DIVIDE = fail_safe_monitor_pkg::RC_DIV
) (
  input wire logic                   ref_clk,
  input wire logic                   sys_rst,
  input wire logic                   monitor_enable_cfg,
  input wire fail_safe_monitor_pkg::avmm_req_s    avmm_req,
  input wire logic                   avmm_waitrequest,
  input wire logic [fail_safe_monitor_pkg::DATA_W-1:0] avmm_readdata,
  input wire fail_safe_monitor_pkg::clk_ctrl_s    clk_ctrl,
  input wire logic                   wdt_clear,
  input wire logic                   osc_fail_irq
);
  import fail_safe_monitor_pkg::*;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  logic req_any;
  assign req_any = avmm_req.read | avmm_req.write;
  ////////////////////////////////////////////////////////////////////////
  a_answer_wait : assert property (
    req_any && avmm_waitrequest |=> !avmm_waitrequest)
    else $error("bus request not answered after one wait state");
  a_answer_once : assert property (!avmm_waitrequest |=> avmm_waitrequest)
    else $error("bus answer held longer than one cycle");
  a_idle_wait : assert property (
    !req_any && avmm_waitrequest |=> avmm_waitrequest)
    else $error("bus answer without a request");
  a_unmapped_zero : assert property (avmm_req.read && avmm_waitrequest
    && avmm_req.address[1:0] != 2'h0 |=> avmm_readdata == '0)
    else $error("unmapped read returned nonzero data");
  a_wdt_pulse : assert property (wdt_clear |=> !wdt_clear)
    else $error("watchdog clear longer than one cycle");
  a_rc_kept : assert property (
    monitor_enable_cfg |-> clk_ctrl.internal_rc_clock_run)
    else $error("internal rc stopped while monitor enabled");
  a_fail_internal : assert property (
    $rose(osc_fail_irq) && $past(wdt_clear) |-> clk_ctrl.src == SRC_INTERNAL)
    else $error("failure did not switch to internal clock");
  a_fail_wdclear : assert property (
    $fell(clk_ctrl.src == SRC_PRIMARY) && !clk_ctrl.sleep_active
    && !$past(clk_ctrl.sleep_active)
    && !$past(avmm_req.write) |-> wdt_clear)
    else $error("clock failure did not clear watchdog");
  a_irq_hold : assert property (
    osc_fail_irq && !avmm_req.write && !$past(avmm_req.write)
    |=> osc_fail_irq)
    else $error("fail interrupt dropped without a write");
  c_fail : cover property ($rose(osc_fail_irq));
  c_wdclr : cover property (wdt_clear);
  c_sleep : cover property ($rose(clk_ctrl.sleep_active));
endmodule : fail_safe_monitor_checker

bind fail_safe_clock_monitor fail_safe_monitor_checker #(.RC_DIVIDE(RC_DIVIDE)) u_chk (
  .ref_clk(ref_clk), .sys_rst(sys_rst),
  .monitor_enable_cfg(monitor_enable_cfg), .avmm_req(avmm_req),
  .avmm_waitrequest(avmm_waitrequest), .avmm_readdata(avmm_readdata),
  .clk_ctrl(clk_ctrl), .wdt_clear(wdt_clear), .osc_fail_irq(osc_fail_irq)
);

// >>> bench/fail_safe_clock_monitor_tb.sv
// Self-checking bench for the fail-safe clock monitor
`timescale 1ns/10ps

module fail_safe_clock_monitor_tb;
  import fail_safe_monitor_pkg::*;
  localparam logic [DATA_W-1:0] ST_B = 32'h1 << STATUS_BIT;
  localparam logic [DATA_W-1:0] IFS3 = 32'h3 << IFS_LSB;
  localparam logic [DATA_W-1:0] FLAG = 32'h1 << FAIL_FLAG_BIT;
  logic              ref_clk;
  logic              sys_rst;
  logic              rc_clk;
  logic              osc_run;
  logic              osc_stable;
  logic              mon_clk;
  logic              pri_ready;
  logic              wake;
  logic              xtal_cfg;
  avmm_req_s         req;
  logic              wait_req;
  logic [DATA_W-1:0] rdata;
  clk_ctrl_s         ctl;
  logic              wd_clr;
  logic              irq;
  logic [DATA_W-1:0] d;
  int                err_count;
  int                cmp_count;
  int                wd_count;
  int                w0;
  int                n;
  ////////////////////////////////////////////////////////////////////////
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  initial begin
    rc_clk = 1'b0;
    #1.3;
    forever #10 rc_clk = ~rc_clk;
  end
  always @(posedge ref_clk) if (wd_clr === 1'b1) wd_count++;

  fail_safe_clock_monitor #(.RC_DIVIDE(4)) DUT (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .monitored_clk(mon_clk),
    .internal_rc_clock(rc_clk), .primary_ready(pri_ready),
    .wake_event(wake), .monitor_enable_cfg(1'b1),
    .two_speed_enable_cfg(1'b1), .crystal_mode_cfg(xtal_cfg),
    .wdt_enable(1'b0), .avmm_req(req), .avmm_waitrequest(wait_req),
    .avmm_readdata(rdata), .clk_ctrl(ctl), .wdt_clear(wd_clr),
    .osc_fail_irq(irq)
  );
  ext_osc_model u_osc (
    .run(osc_run), .stable(osc_stable), .osc_out(mon_clk),
    .osc_ready(pri_ready)
  );
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [DATA_W-1:0] got,
                     input logic [DATA_W-1:0] exp, input string msg);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: %s", $time, msg);
    end
  endtask : chk

  task automatic chk_src(input clk_src_e e);
    chk({30'h0, ctl.src}, {30'h0, e}, "clock source");
  endtask : chk_src

  task automatic bus(input logic wr, input logic [ADDR_W-1:0] a,
                     input logic [DATA_W-1:0] wd);
    @(posedge ref_clk);
    req.read      <= ~wr;
    req.write     <= wr;
    req.address   <= a;
    req.writedata <= wd;
    do @(posedge ref_clk); while (wait_req !== 1'b0);
    d = rdata;
    req.read  <= 1'b0;
    req.write <= 1'b0;
  endtask : bus

  task automatic wait_irq();
    int k;
    k = 0;
    while (irq !== 1'b1 && k < 300) begin
      @(posedge ref_clk);
      k++;
    end
    chk({31'h0, irq}, 32'h1, "fail interrupt");
  endtask : wait_irq

  function automatic logic [DATA_W-1:0] mode_val(input logic [3:0] s,
      input logic pm, input logic [1:0] c);
    mode_val = (DATA_W'(c) << RD_SRC_LSB) | (DATA_W'(pm) << RD_PM_BIT)
             | DATA_W'(s);
  endfunction : mode_val

  task automatic stop_test();
    $display("compares %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : stop_test
  ////////////////////////////////////////////////////////////////////////
  initial begin
    #100000;
    err_count++;
    $display("mismatch at %0t: run timed out", $time);
    stop_test();
  end

  initial begin
    sys_rst = 1'b1;
    req = '0;
    osc_run = 1'b0;
    osc_stable = 1'b0;
    wake = 1'b0;
    xtal_cfg = 1'b1;
    err_count = 0;
    cmp_count = 0;
    wd_count = 0;
    repeat (8) @(posedge ref_clk);
    sys_rst <= 1'b0;
    @(posedge ref_clk);
    chk_src(SRC_INTERNAL);
    bus(1'b0, OFS_OSC_CTRL, '0);
    chk(d, '0, "control at reset");
    bus(1'b0, OFS_MODE_CTRL, '0);
    chk(d, mode_val(4'h1, 1'b0, SRC_INTERNAL), "startup mode");
    bus(1'b0, 4'h2, '0);
    chk(d, '0, "unmapped read");
    w0 = wd_count;
    bus(1'b1, OFS_OSC_CTRL, IFS3 | ST_B);
    bus(1'b0, OFS_OSC_CTRL, '0);
    chk(d, IFS3, "status read only");
    chk(DATA_W'(wd_count - w0), 32'h1, "freq change clear");
    osc_stable <= 1'b1;
    n = 0;
    do begin
      bus(1'b0, OFS_OSC_CTRL, '0);
      n++;
    end while (d[STATUS_BIT] !== 1'b1 && n < 40);
    chk(d, IFS3 | ST_B, "primary status");
    chk_src(SRC_PRIMARY);
    bus(1'b1, OFS_IRQ_EN, FLAG);
    w0 = wd_count;
    osc_run <= 1'b1;
    wait_irq();
    osc_run <= 1'b0;
    chk_src(SRC_INTERNAL);
    bus(1'b0, OFS_OSC_CTRL, '0);
    chk(d, IFS3 | ST_B, "control unchanged");
    bus(1'b0, OFS_IRQ_FLAGS, '0);
    chk(d, FLAG, "fail flag");
    chk(DATA_W'(wd_count - w0), 32'h1, "fail watchdog clear");
    bus(1'b1, OFS_IRQ_FLAGS, '0);
    bus(1'b0, OFS_IRQ_FLAGS, '0);
    chk(d, '0, "flag cleared");
    bus(1'b0, OFS_MODE_CTRL, '0);
    chk(d, mode_val(4'h8, 1'b0, SRC_INTERNAL), "fail-safe kept");
    bus(1'b1, OFS_MODE_CTRL, 32'h1 << IDLE_BIT);
    bus(1'b0, OFS_MODE_CTRL, '0);
    chk(d, mode_val(4'h2, 1'b1, SRC_PRIMARY), "pm entry");
    chk_src(SRC_PRIMARY);
    w0 = wd_count;
    osc_run <= 1'b1;
    wait_irq();
    osc_run <= 1'b0;
    repeat (50) @(posedge ref_clk);
    chk_src(SRC_INTERNAL);
    chk({31'h0, ctl.pm_active}, '0, "managed mode left");
    bus(1'b1, OFS_MODE_CTRL, 32'h1 << WDCLR_BIT);
    bus(1'b0, OFS_IRQ_FLAGS, '0);
    chk(d, FLAG, "flag set again");
    chk(DATA_W'(wd_count - w0), 32'h2, "watchdog clears");
    osc_stable <= 1'b0;
    sys_rst <= 1'b1;
    repeat (8) @(posedge ref_clk);
    sys_rst <= 1'b0;
    repeat (100) @(posedge ref_clk);
    bus(1'b0, OFS_OSC_CTRL, '0);
    chk(d, '0, "primary never ready");
    chk_src(SRC_INTERNAL);
    bus(1'b1, OFS_OSC_CTRL, 32'h1);
    @(posedge ref_clk);
    chk({31'h0, ctl.primary_en}, '0, "primary disabled");
    chk_src(SRC_SECONDARY);
    w0 = wd_count;
    bus(1'b1, OFS_MODE_CTRL, 32'h1 << SLEEP_BIT);
    repeat (3) @(negedge ref_clk);
    chk({31'h0, ctl.sleep_active}, 32'h1, "sleep taken");
    chk(DATA_W'(wd_count - w0), 32'h1, "sleep clear");
    @(posedge ref_clk);
    wake <= 1'b1;
    repeat (6) @(posedge ref_clk);
    wake <= 1'b0;
    repeat (4) @(negedge ref_clk);
    chk({31'h0, ctl.sleep_active}, '0, "woken");
    chk_src(SRC_INTERNAL);
    // Non-crystal primary, then failure in managed mode, interrupt off
    @(posedge ref_clk);
    xtal_cfg <= 1'b0;
    sys_rst  <= 1'b1;
    repeat (8) @(posedge ref_clk);
    sys_rst <= 1'b0;
    repeat (4) @(posedge ref_clk);
    bus(1'b0, OFS_OSC_CTRL, '0);
    chk(d, ST_B, "non-crystal start");
    chk_src(SRC_PRIMARY);
    chk({31'h0, ctl.internal_rc_clock_run}, 32'h1, "rc kept running");
    bus(1'b1, OFS_MODE_CTRL, 32'h1 << IDLE_BIT);
    osc_run <= 1'b1;
    repeat (60) @(posedge ref_clk);
    osc_run <= 1'b0;
    bus(1'b0, OFS_MODE_CTRL, '0);
    chk(d, mode_val(4'h8, 1'b1, SRC_INTERNAL), "managed fail");
    chk({31'h0, ctl.pm_active}, 32'h1, "managed mode kept");
    bus(1'b0, OFS_IRQ_FLAGS, '0);
    chk(d, FLAG, "flag without enable");
    chk({31'h0, irq}, '0, "interrupt masked");
    stop_test();
  end
endmodule : fail_safe_clock_monitor_tb
